// file: flash_ctrl_pkg.sv
// constants shared by the on-chip flash controller and its testbench
// assumes a 32-bit apb register bus and a word-addressed flash array
package flash_ctrl_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_ADDR = 8'h00;
	localparam logic [7:0] OFS_DATA = 8'h04;
	localparam logic [7:0] OFS_CMD = 8'h08;
	localparam logic [7:0] OFS_USEC = 8'h0C;
	localparam logic [7:0] OFS_PROT = 8'h10;
	localparam logic [7:0] OFS_RAW = 8'h14;
	localparam logic [7:0] OFS_MASK = 8'h18;
	localparam logic [7:0] OFS_MIS = 8'h1C;
	localparam logic [7:0] OFS_STAT = 8'h20;
	// command register fields
	localparam int CMD_PROG_BIT = 0;
	localparam int CMD_ERASE_BIT = 1;
	localparam int CMD_COMMIT_BIT = 2;
	// interrupt bit positions
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_ACC_BIT = 1;
	// status register fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_FAIL_BIT = 1;
	localparam int STAT_COMMIT_BIT = 2;
	// protection encodings, larger is stricter
	localparam logic [1:0] PROT_RW = 2'h0;
	localparam logic [1:0] PROT_RO = 2'h1;
	localparam logic [1:0] PROT_XO = 2'h2;
	// reset values
	localparam logic [7:0] USEC_RST = 8'h64;
	localparam logic [1:0] MASK_RST = 2'h0;
	// pulse lengths in microseconds
	localparam int PROG_US = 20;
	localparam int ERASE_US = 100;
	// erase block of 1 kB is 256 words, protect region of 2 kB is 512 words
	localparam int ERASE_WORDS_LOG2 = 8;
	localparam int PROT_WORDS_LOG2 = 9;
	localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;
endpackage : flash_ctrl_pkg

// file: flash_pulse_timer.sv
// microsecond pulse timer for program and erase strobes
// assumes usec_in is loaded by software with clocks per microsecond
`timescale 1ns/1ns
`default_nettype none
module flash_pulse_timer (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	// control
	input wire logic start_in,
	input wire logic [7:0] usec_in,
	input wire logic [7:0] len_us_in,
	// result
	output logic busy_out,
	output logic done_out
);
	logic [7:0] cyc_r; // cycles within the current microsecond
	logic [7:0] us_r; // microseconds left
	logic busy_r;
	logic done_r;
	logic tick; // one-cycle microsecond enable

	// a zero rate is treated as one cycle per microsecond
	assign tick = busy_r && (cyc_r + 8'h01 >= usec_in);

	// microsecond divider and countdown
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cyc_r <= 8'h00;
			us_r <= 8'h00;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (start_in && !busy_r) begin
				cyc_r <= 8'h00;
				us_r <= len_us_in;
				busy_r <= 1'b1;
			end else if (tick) begin
				cyc_r <= 8'h00;
				if (us_r <= 8'h01) begin
					busy_r <= 1'b0; // pulse ends
					done_r <= 1'b1;
				end else begin
					us_r <= us_r - 8'h01;
				end
			end else if (busy_r) begin
				cyc_r <= cyc_r + 8'h01;
			end
		end
	end

	assign busy_out = busy_r;
	assign done_out = done_r;
endmodule : flash_pulse_timer
`default_nettype wire

// file: onchip_flash_controller.sv
// on-chip flash controller: erase, word program, region protection, irq
// assumes an apb master on clk_sys_in and one fetch/read port from the core
//
// What this block does
// - erase sets whole 1 kB block to ones
// - one protection setting per 2 kB region
// - read-only regions refuse erase and program
// - execute-only allows fetches only
// - program one word, ones to zeros only
// - pulses timed from clocks-per-microsecond value
// - forbidden access sets violation flag
// - finished erase or program sets done flag
// - only enabled sources drive interrupt line
// - writing one clears selected flags
// - commit sets a sticky status flag; protection rules do not depend on it
// - bad or protected erase rejected with failure
// - raw and masked status both readable
// - protection only tightens, execute-only frozen
`timescale 1ns/1ns
`default_nettype none
module onchip_flash_controller #(
	parameter int WORDS = 4096, // array size in 32-bit words
	parameter int AW = 12 // word address width
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// core and debugger read port
	input wire logic rd_req_in,
	input wire logic rd_fetch_in, // high for instruction fetch
	input wire logic [AW-1:0] rd_addr_in,
	output logic [31:0] rd_data_out,
	output logic rd_valid_out,
	// interrupt and busy
	output logic irq_out,
	output logic busy_out
);
	localparam int NREG = WORDS >> flash_ctrl_pkg::PROT_WORDS_LOG2;
	localparam int RW = AW - flash_ctrl_pkg::PROT_WORDS_LOG2;
	localparam int ERASE_W = flash_ctrl_pkg::ERASE_WORDS_LOG2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_PROG = 3'b010,
		ST_ERASE = 3'b100
	} op_e;

	logic [31:0] mem_r [WORDS]; // flash array
	logic [1:0] prot_r [NREG]; // live protection per 2 kB region
	logic [AW-1:0] addr_r; // target word address
	logic [31:0] data_r; // program data
	logic [7:0] usec_r; // clocks per microsecond
	logic [1:0] raw_r; // sticky irq flags
	logic [1:0] mask_r; // irq enables
	logic fail_r; // last command refused
	logic commit_r; // commit seen, sticky status bit only; protection does not use it
	logic [31:0] prdata_r;
	logic [31:0] rd_data_r;
	logic rd_valid_r;
	op_e op_r;
	logic [ERASE_W-1:0] ecnt_r; // erase word walker
	logic addr_oor_r; // written address lies beyond the array

	logic wr_en; // apb write access phase
	logic rd_en; // apb read access phase
	logic cmd_prog;
	logic cmd_erase;
	logic cmd_commit;
	logic cmd_ok; // command accepted
	logic cmd_bad; // command refused
	logic tmr_busy;
	logic tmr_done;
	logic tmr_start;
	logic [7:0] tmr_len;
	logic rd_bad; // forbidden read
	logic prot_bad; // forbidden protection change
	logic [1:0] ev_set; // events this cycle
	logic [1:0] wr_clr; // write-one-to-clear bits

	// region index of a word address
	function automatic logic [RW-1:0] region_of(input logic [AW-1:0] a);
		region_of = a[AW-1:flash_ctrl_pkg::PROT_WORDS_LOG2];
	endfunction : region_of

	// zero-wait apb: every access completes in its first access cycle
	assign pready_out = 1'b1;
	assign pslverr_out = 1'b0;
	assign wr_en = psel_in && penable_in && pwrite_in;
	assign rd_en = psel_in && penable_in && !pwrite_in;

	// command decode on write to the command register
	assign cmd_prog = wr_en && paddr_in == flash_ctrl_pkg::OFS_CMD
		&& pwdata_in[flash_ctrl_pkg::CMD_PROG_BIT];
	assign cmd_erase = wr_en && paddr_in == flash_ctrl_pkg::OFS_CMD
		&& pwdata_in[flash_ctrl_pkg::CMD_ERASE_BIT] && !cmd_prog;
	assign cmd_commit = wr_en && paddr_in == flash_ctrl_pkg::OFS_CMD
		&& pwdata_in[flash_ctrl_pkg::CMD_COMMIT_BIT];
	// refuse when busy, out of range or region not read/write
	assign cmd_bad = (cmd_prog || cmd_erase) && (op_r != ST_IDLE
		|| addr_oor_r || 32'(addr_r) >= WORDS
		|| prot_r[region_of(addr_r)] != flash_ctrl_pkg::PROT_RW);
	assign cmd_ok = (cmd_prog || cmd_erase) && !cmd_bad;

	// protection change that would loosen a region or touch a frozen one
	assign prot_bad = wr_en && paddr_in == flash_ctrl_pkg::OFS_PROT
		&& (prot_r[region_of(pwdata_in[AW+15:16])] == flash_ctrl_pkg::PROT_XO
		|| pwdata_in[1:0] < prot_r[region_of(pwdata_in[AW+15:16])]
		|| pwdata_in[1:0] > flash_ctrl_pkg::PROT_XO);

	// data reads of execute-only regions are blocked
	assign rd_bad = rd_req_in && !rd_fetch_in
		&& prot_r[region_of(rd_addr_in)] == flash_ctrl_pkg::PROT_XO;
	assign tmr_start = cmd_ok;
	assign tmr_len = cmd_erase ? 8'(flash_ctrl_pkg::ERASE_US) : 8'(flash_ctrl_pkg::PROG_US);
	flash_pulse_timer u_timer (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.start_in(tmr_start),
		.usec_in(usec_r),
		.len_us_in(tmr_len),
		.busy_out(tmr_busy),
		.done_out(tmr_done)
	);

	// events and clears; set wins over clear
	assign ev_set[flash_ctrl_pkg::IRQ_DONE_BIT] = (op_r == ST_PROG && tmr_done)
		|| (op_r == ST_ERASE && !tmr_busy && ecnt_r == '1);
	assign ev_set[flash_ctrl_pkg::IRQ_ACC_BIT] = rd_bad || cmd_bad || prot_bad;
	assign wr_clr = (wr_en && paddr_in == flash_ctrl_pkg::OFS_RAW) ? pwdata_in[1:0] : 2'h0;

	// sticky raw interrupt flags
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			raw_r <= 2'h0;
		end else begin
			raw_r <= (raw_r & ~wr_clr) | ev_set;
		end
	end

	// software-owned configuration registers
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			addr_r <= '0;
			addr_oor_r <= 1'b0;
			data_r <= 32'h00000000;
			usec_r <= flash_ctrl_pkg::USEC_RST;
			mask_r <= flash_ctrl_pkg::MASK_RST;
		end else if (wr_en) begin
			unique case (paddr_in)
				flash_ctrl_pkg::OFS_ADDR: begin
					addr_r <= pwdata_in[AW+1:2]; // byte address in
					addr_oor_r <= |pwdata_in[31:AW+2];
				end
				flash_ctrl_pkg::OFS_DATA: data_r <= pwdata_in;
				flash_ctrl_pkg::OFS_USEC: usec_r <= pwdata_in[7:0];
				flash_ctrl_pkg::OFS_MASK: mask_r <= pwdata_in[1:0];
				default: ; // other offsets hold no field stored in this block
			endcase
		end
	end

	// result of the last command, cleared by the next accepted one
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			fail_r <= 1'b0;
		end else if (cmd_bad || prot_bad) begin
			fail_r <= 1'b1;
		end else if (cmd_ok) begin
			fail_r <= 1'b0;
		end
	end

	// protection table; commit is sticky until power loss in real silicon
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			commit_r <= 1'b0;
			for (int i = 0; i < NREG; i++) begin
				prot_r[i] <= flash_ctrl_pkg::PROT_RW;
			end
		end else begin
			if (cmd_commit) begin
				commit_r <= 1'b1;
			end
			if (wr_en && paddr_in == flash_ctrl_pkg::OFS_PROT && !prot_bad) begin
				prot_r[region_of(pwdata_in[AW+15:16])] <= pwdata_in[1:0];
			end
		end
	end

	// operation sequencer; program write lands when the timed pulse ends, erase writes while it runs
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			op_r <= ST_IDLE;
			ecnt_r <= '0;
		end else begin
			unique case (op_r)
				ST_IDLE: begin
					ecnt_r <= '0;
					if (cmd_ok) begin
						op_r <= cmd_erase ? ST_ERASE : ST_PROG;
					end
				end
				ST_PROG: begin
					if (tmr_done) begin
						op_r <= ST_IDLE;
					end
				end
				ST_ERASE: begin
					// walk the block, one word per cycle, while the pulse runs
					if (ecnt_r != '1) begin
						ecnt_r <= ecnt_r + 1'b1;
					end
					if (ev_set[flash_ctrl_pkg::IRQ_DONE_BIT]) begin
						op_r <= ST_IDLE;
					end
				end
				default: op_r <= ST_IDLE;
			endcase
		end
	end

	// flash array contents; no reset, like real cells
	always_ff @(posedge clk_sys_in) begin
		if (op_r == ST_PROG && tmr_done) begin
			mem_r[addr_r] <= mem_r[addr_r] & data_r;
		end
		if (op_r == ST_ERASE) begin
			mem_r[{addr_r[AW-1:ERASE_W], ecnt_r}] <= flash_ctrl_pkg::ERASED_WORD;
		end
	end

	// core read port, one cycle latency, blocked reads return zero
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rd_data_r <= 32'h00000000;
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= rd_req_in;
			if (rd_req_in) begin
				rd_data_r <= rd_bad ? 32'h00000000 : mem_r[rd_addr_in];
			end
		end
	end

	// apb read mux, registered in the setup cycle
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			prdata_r <= 32'h00000000;
		end else if (psel_in && !penable_in && !pwrite_in) begin
			unique case (paddr_in)
				flash_ctrl_pkg::OFS_ADDR: prdata_r <= 32'({addr_r, 2'b00});
				flash_ctrl_pkg::OFS_DATA: prdata_r <= data_r;
				flash_ctrl_pkg::OFS_USEC: prdata_r <= {24'h000000, usec_r};
				flash_ctrl_pkg::OFS_PROT: prdata_r <= {30'h00000000, prot_r[region_of(addr_r)]};
				flash_ctrl_pkg::OFS_RAW: prdata_r <= {30'h00000000, raw_r};
				flash_ctrl_pkg::OFS_MASK: prdata_r <= {30'h00000000, mask_r};
				flash_ctrl_pkg::OFS_MIS: prdata_r <= {30'h00000000, raw_r & mask_r};
				flash_ctrl_pkg::OFS_STAT: prdata_r <= {29'h00000000, commit_r, fail_r,
					op_r != ST_IDLE};
				default: prdata_r <= 32'h00000000; // unmapped reads zero
			endcase
		end
	end

	assign prdata_out = rd_en ? prdata_r : 32'h00000000;
	assign irq_out = |(raw_r & mask_r);
	assign busy_out = op_r != ST_IDLE;
	assign rd_data_out = rd_data_r;
	assign rd_valid_out = rd_valid_r;

	// a refused command never starts the sequencer
	property p_refuse_no_start;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		cmd_bad |=> fail_r && ($past(op_r) != ST_IDLE || op_r == ST_IDLE);
	endproperty
	a_refuse_no_start: assert property (p_refuse_no_start) else $error("refused op started");

	// execute-only data read flags violation next cycle
	property p_xo_read;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		rd_bad |=> raw_r[flash_ctrl_pkg::IRQ_ACC_BIT] && rd_data_r == 32'h00000000;
	endproperty
	a_xo_read: assert property (p_xo_read) else $error("xo read leaked");

	// completion sets the done flag
	property p_done_flag;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		ev_set[flash_ctrl_pkg::IRQ_DONE_BIT] |=> raw_r[flash_ctrl_pkg::IRQ_DONE_BIT] && !busy_out;
	endproperty
	a_done_flag: assert property (p_done_flag) else $error("done flag missing");

	// interrupt line follows masked flags
	property p_irq_mask;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		irq_out == |(raw_r & mask_r);
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq not masked");

	// write-one clears a flag without a new event
	property p_clear;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(wr_clr[0] && !ev_set[0]) |=> !raw_r[0];
	endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared");

	// commit never falls back
	property p_commit;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		commit_r |=> commit_r;
	endproperty
	a_commit: assert property (p_commit) else $error("commit reverted");

	// protection of the addressed region never loosens
	property p_tighten;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		##1 prot_r[region_of(addr_r)] >= $past(prot_r[region_of(addr_r)]) || addr_r != $past(addr_r);
	endproperty
	a_tighten: assert property (p_tighten) else $error("protection loosened");

	// accepted op raises busy and timer busy on the next cycle
	property p_busy;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		cmd_ok |=> busy_out && tmr_busy;
	endproperty
	a_busy: assert property (p_busy) else $error("busy missing");
endmodule : onchip_flash_controller
`default_nettype wire

// file: flash_core_model.sv
// core and debugger side of the flash read port, driven by task calls
// assumes the controller answers one cycle after the edge that takes a request
`timescale 1ns/1ns
`default_nettype none
module flash_core_model #(
	parameter int AW = 12 // word address width
) (
	// clock
	input wire logic clk_sys_in,
	// request towards the controller
	output logic rd_req_out,
	output logic rd_fetch_out,
	output logic [AW-1:0] rd_addr_out,
	// answer from the controller
	input wire logic [31:0] rd_data_in,
	input wire logic rd_valid_in
);
	// idle at time zero, nothing requested
	initial begin
		rd_req_out = 1'b0;
		rd_fetch_out = 1'b0;
		rd_addr_out = '0;
	end

	// one read: fetch high for an instruction fetch, low for a data read
	task automatic read_word(input logic fetch, input logic [AW-1:0] addr,
		output logic [31:0] data);
		int guard;
		guard = 0;
		data = 'x;
		@(posedge clk_sys_in);
		rd_req_out <= 1'b1;
		rd_fetch_out <= fetch;
		rd_addr_out <= addr;
		@(posedge clk_sys_in);
		// taken at this edge; released address shows the inverse, not a stale copy
		rd_req_out <= 1'b0;
		rd_fetch_out <= ~fetch;
		rd_addr_out <= ~addr;
		// bounded wait so a dead port shows as an unknown word
		while (rd_valid_in !== 1'b1 && guard < 8) begin
			@(posedge clk_sys_in);
			guard++;
		end
		if (rd_valid_in === 1'b1) data = rd_data_in;
	endtask : read_word
endmodule : flash_core_model
`default_nettype wire

// file: onchip_flash_controller_tb.sv
// self-checking bench: apb register tasks, core reads, commands, protection
// assumes the package, the design and the core read model are compiled first
`timescale 1ns/1ns
`default_nettype none
module onchip_flash_controller_tb;
	logic clk_sys_in = 1'b0; // system clock
	logic nrst_in = 1'b0; // async reset, low active
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb controls
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, prdata, q;
	logic pready, pslverr, rd_req, rd_fetch, rd_valid, irq, busy;
	logic [11:0] rd_addr;
	logic [31:0] rd_data;
	int num_errors = 0, n_compared = 0;
	// command words built from the package bit positions
	localparam logic [31:0] C_PR = 32'h1 << flash_ctrl_pkg::CMD_PROG_BIT;
	localparam logic [31:0] C_ER = 32'h1 << flash_ctrl_pkg::CMD_ERASE_BIT;
	localparam logic [31:0] C_CM = 32'h1 << flash_ctrl_pkg::CMD_COMMIT_BIT;
	localparam int CYC_US = 4; // clocks per microsecond used by the bench

	// 100 MHz clock
	always #5 clk_sys_in = ~clk_sys_in;

	onchip_flash_controller dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .rd_req_in(rd_req),
		.rd_fetch_in(rd_fetch), .rd_addr_in(rd_addr), .rd_data_out(rd_data),
		.rd_valid_out(rd_valid), .irq_out(irq), .busy_out(busy));
	flash_core_model core (.clk_sys_in(clk_sys_in), .rd_req_out(rd_req),
		.rd_fetch_out(rd_fetch), .rd_addr_out(rd_addr), .rd_data_in(rd_data),
		.rd_valid_in(rd_valid));

	// one comparison, counted
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// one apb transfer: setup, access until pready, then release
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int g;
		g = 0;
		@(posedge clk_sys_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_in);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys_in);
			g++;
		end while (pready !== 1'b1 && g < 16);
		if (pready !== 1'b1) num_errors++; // a stalled bus counts as a mismatch
		q = prdata;
		check("pslverr", 32'h0, 32'(pslverr));
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// masked register read compare
	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		apb(1'b0, a, 32'h00000000);
		check(n, e, q & m);
	endtask : rchk

	// core read compare
	task automatic cr(input string n, input logic f, input logic [11:0] a, input logic [31:0] e);
		core.read_word(f, a, q);
		check(n, e, q);
	endtask : cr

	// issue a command; accepted ones must stay busy us cycles plus a short tail
	task automatic cmd(input logic [31:0] adr, input logic [31:0] c, input int us,
		input logic ok);
		int n, g;
		n = 0;
		g = 0;
		apb(1'b1, flash_ctrl_pkg::OFS_ADDR, adr);
		apb(1'b1, flash_ctrl_pkg::OFS_CMD, c);
		while (busy !== 1'b1 && g < 4) begin
			@(posedge clk_sys_in);
			g++;
		end
		while (busy === 1'b1 && n < 4000) begin
			@(posedge clk_sys_in);
			n++;
		end
		if (ok) check("busy_span", 32'h1, 32'(n >= us && n <= us + 16));
		else check("refused_busy", 32'h0, 32'(n));
	endtask : cmd

	// irq level after the next edge has landed
	task automatic irq_is(input logic e);
		@(posedge clk_sys_in);
		#1;
		check("irq", 32'(e), 32'(irq));
	endtask : irq_is

	// single exit for both the tests and the watchdog
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	// watchdog, far beyond the few thousand cycles the tests need
	initial begin
		#500000;
		num_errors++;
		print_verdict();
	end

	// main sequence
	initial begin
		repeat (5) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		rchk("usec_rst", flash_ctrl_pkg::OFS_USEC, 32'h00000064, 32'hFF);
		rchk("mask_rst", flash_ctrl_pkg::OFS_MASK, 32'h0, 32'h3);
		rchk("stat_rst", flash_ctrl_pkg::OFS_STAT, 32'h0, 32'h7);
		rchk("unmapped", 8'h24, 32'h0, 32'hFFFFFFFF);
		// few clocks per microsecond keeps pulses short, erase still outlasts the block walk
		apb(1'b1, flash_ctrl_pkg::OFS_USEC, 32'(CYC_US));
		cmd(32'h0, C_ER, flash_ctrl_pkg::ERASE_US * CYC_US, 1'b1);
		cr("erased_lo", 1'b0, 12'h000, flash_ctrl_pkg::ERASED_WORD);
		cr("erased_hi", 1'b0, 12'h0FF, flash_ctrl_pkg::ERASED_WORD);
		rchk("raw_done", flash_ctrl_pkg::OFS_RAW, 32'h1, 32'h3);
		irq_is(1'b0);
		apb(1'b1, flash_ctrl_pkg::OFS_MASK, 32'h1);
		irq_is(1'b1);
		rchk("mis_done", flash_ctrl_pkg::OFS_MIS, 32'h1, 32'h3);
		// handler style: clear first
		apb(1'b1, flash_ctrl_pkg::OFS_RAW, 32'h1);
		irq_is(1'b0);
		apb(1'b1, flash_ctrl_pkg::OFS_DATA, 32'hA5A55A5A);
		cmd(32'h14, C_PR, flash_ctrl_pkg::PROG_US * CYC_US, 1'b1);
		cr("prog1", 1'b0, 12'h005, 32'hA5A55A5A);
		apb(1'b1, flash_ctrl_pkg::OFS_DATA, 32'h0000FFFF);
		cmd(32'h14, C_PR, flash_ctrl_pkg::PROG_US * CYC_US, 1'b1);
		cr("prog_and", 1'b0, 12'h005, 32'h00005A5A);
		cmd(32'h800, C_ER, flash_ctrl_pkg::ERASE_US * CYC_US, 1'b1);
		apb(1'b1, flash_ctrl_pkg::OFS_RAW, 32'h3);
		// beyond the array while region 0 is still read/write
		cmd(32'h4000, C_ER, 0, 1'b0);
		rchk("raw_range", flash_ctrl_pkg::OFS_RAW, 32'h2, 32'h3);
		apb(1'b1, flash_ctrl_pkg::OFS_RAW, 32'h3);
		// region 0 read-only, region 1 untouched
		apb(1'b1, flash_ctrl_pkg::OFS_PROT, 32'(flash_ctrl_pkg::PROT_RO));
		apb(1'b1, flash_ctrl_pkg::OFS_ADDR, 32'h0);
		rchk("prot_r0", flash_ctrl_pkg::OFS_PROT, 32'h1, 32'h3);
		apb(1'b1, flash_ctrl_pkg::OFS_ADDR, 32'h800);
		rchk("prot_r1", flash_ctrl_pkg::OFS_PROT, 32'h0, 32'h3);
		apb(1'b1, flash_ctrl_pkg::OFS_DATA, 32'h00000000);
		cmd(32'h14, C_PR, 0, 1'b0);
		cr("ro_kept", 1'b0, 12'h005, 32'h00005A5A);
		rchk("fail_bit", flash_ctrl_pkg::OFS_STAT, 32'h2, 32'h3);
		rchk("raw_acc", flash_ctrl_pkg::OFS_RAW, 32'h2, 32'h3);
		apb(1'b1, flash_ctrl_pkg::OFS_RAW, 32'h3);
		cmd(32'h400, C_ER, 0, 1'b0);
		rchk("raw_ro_er", flash_ctrl_pkg::OFS_RAW, 32'h2, 32'h3);
		// loosening must not take
		apb(1'b1, flash_ctrl_pkg::OFS_PROT, 32'(flash_ctrl_pkg::PROT_RW));
		apb(1'b1, flash_ctrl_pkg::OFS_ADDR, 32'h0);
		rchk("no_loosen", flash_ctrl_pkg::OFS_PROT, 32'h1, 32'h3);
		apb(1'b1, flash_ctrl_pkg::OFS_RAW, 32'h3);
		// region 1 execute-only, only the access source enabled
		apb(1'b1, flash_ctrl_pkg::OFS_MASK, 32'h2);
		apb(1'b1, flash_ctrl_pkg::OFS_PROT, (32'h200 << 16) | 32'(flash_ctrl_pkg::PROT_XO));
		cr("xo_data", 1'b0, 12'h200, 32'h0);
		irq_is(1'b1);
		cr("xo_fetch", 1'b1, 12'h200, flash_ctrl_pkg::ERASED_WORD);
		apb(1'b1, flash_ctrl_pkg::OFS_PROT, (32'h200 << 16) | 32'(flash_ctrl_pkg::PROT_RO));
		apb(1'b1, flash_ctrl_pkg::OFS_ADDR, 32'h800);
		rchk("xo_frozen", flash_ctrl_pkg::OFS_PROT, 32'h2, 32'h3);
		cmd(32'h800, C_ER, 0, 1'b0);
		apb(1'b1, flash_ctrl_pkg::OFS_RAW, 32'h3);
		irq_is(1'b0);
		apb(1'b1, flash_ctrl_pkg::OFS_CMD, C_CM);
		rchk("committed", flash_ctrl_pkg::OFS_STAT, 32'h4, 32'h5);
		print_verdict();
	end
endmodule : onchip_flash_controller_tb
`default_nettype wire
